// ===== refclk_pkg.sv
// Shared constants for reference clock switchover and divider logic
package refclk_pkg;
    localparam logic [7:0] CFG_SWITCH_FIRST = 8'h00_BE;
    localparam logic [7:0] CFG_SWITCH_LAST = 8'h00_C3;
    localparam logic [7:0] CFG_SPREAD_FIRST = 8'h00_AC;
    localparam logic [7:0] CFG_SPREAD_LAST = 8'h00_BD;
    localparam int LOSS_THRESHOLD = 2;
    localparam logic [1:0] LOSS_CNT_MAX = 2'h2;
    localparam int LOADCAP_BASE_MILLI_PF = 3500;
    localparam int LOADCAP_STEP_MILLI_PF = 125;
    localparam logic [4:0] LOADCAP_RESET = 5'h00;
    localparam logic [1:0] DRIVE_RESET = 2'h3;
    localparam logic [6:0] QDIV_ALL_ONES = 7'h7F;
    localparam logic [1:0] OEM_LOW = 2'h0;
    localparam logic [1:0] OEM_HIGH = 2'h1;
    localparam logic [1:0] OEM_HIZ = 2'h2;
    localparam int NUM_BANKS = 6;
    localparam int NUM_PLLS = 4;
    typedef enum logic [2:0] {
        SRC_PRIMARY = 3'b001,
        SRC_SECONDARY = 3'b010,
        SRC_REVERT = 3'b100
    } src_state_t;
endpackage

// ===== out_divider.sv
// One output bank divider with prescale select and disabled state
module out_divider (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_prescale_select,
    input wire logic [6:0] i_qdiv,
    input wire logic [1:0] i_disabled_output_state,
    output logic o_clk,
    output logic o_oe,
    output logic o_running,
    output logic [8:0] o_ratio
);
    logic [7:0] cnt_r;
    logic tog_r;
    logic all_ones;
    logic disabled;
    logic bypass;
    logic [7:0] half;
    assign all_ones = (i_qdiv == refclk_pkg::QDIV_ALL_ONES);
    assign disabled = all_ones && !i_prescale_select;
    assign bypass = all_ones && i_prescale_select;
    // Half period in ticks: 1 for /2, Q+2 for (Q+2)*2
    assign half = i_prescale_select ? ({1'b0, i_qdiv} + 8'h02) : 8'h01;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_r <= 8'h00;
            tog_r <= 1'b0;
        end else if (i_ce && !disabled && !bypass) begin
            if (cnt_r + 8'h01 >= half) begin
                cnt_r <= 8'h00;
                tog_r <= ~tog_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
    // Divider stays powered but its counter holds while disabled; the pin level is forced
    always_comb begin
        o_oe = 1'b1;
        if (disabled) begin
            o_clk = (i_disabled_output_state == refclk_pkg::OEM_HIGH);
            o_oe = (i_disabled_output_state != refclk_pkg::OEM_HIZ);
        end else if (bypass) begin
            o_clk = i_clk_sys;
        end else begin
            o_clk = tog_r;
        end
    end
    assign o_running = !disabled;
    always_comb begin
        if (disabled) o_ratio = 9'h000;
        else if (bypass) o_ratio = 9'h001;
        else o_ratio = {half, 1'b0};
    end
endmodule

// ===== loss_detect.sv
// Loss-of-primary detector counting secondary clock ticks
module loss_detect (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_prim_edge,
    input wire logic i_sec_edge,
    output logic o_lost
);
    logic [1:0] cnt_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_r <= 2'h0;
        end else if (i_ce) begin
            if (i_prim_edge) cnt_r <= 2'h0;
            else if (i_sec_edge && cnt_r != refclk_pkg::LOSS_CNT_MAX) cnt_r <= cnt_r + 2'h1;
        end
    end
    assign o_lost = (cnt_r == refclk_pkg::LOSS_CNT_MAX);
endmodule

// ===== ref_clock_switchover_dividers.sv
// Reference selection, switchover, PLL divider values and output banks
//
// Contract
// - Select pin chooses crystal or auxiliary input
// - Primary source bit picks primary input
// - Switchover config lives at 0xBE-0xC3
// - Mode upper bit zero means manual
// - Manual mode follows select pin glitch-free
// - Auto switches after two secondary cycles loss
// - Auto mode reverts to primary when present
// - Switch asynchronous; bypass outputs may glitch
// - Load cap 3.5 pF plus code*0.125
// - 7-bit reference, 12-bit feedback dividers
// - First PLL M=2N+A+1, else 2N (PLLs 1-3 here total N)
// - Undivided output has no divider
// - Prescale and count pick divide ratio
// - Disabled output high, low or hi-Z
// - Disabled divider powered but clockless
// - Spread active when step period nonzero
// - Spread config lives at 0xAC-0xBD
module ref_clock_switchover_dividers (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_crystal_ref_input,
    input wire logic i_auxiliary_clock_input,
    input wire logic i_input_select_pin,
    input wire logic i_primary_source_bit,
    input wire logic [1:0] i_switchover_mode_field,
    input wire logic [4:0] i_load_cap_code,
    input wire logic [1:0] i_crystal_drive_strength,
    input wire logic [6:0] i_ref_div_0,
    input wire logic [6:0] i_ref_div_1,
    input wire logic [6:0] i_ref_div_2,
    input wire logic [6:0] i_ref_div_3,
    input wire logic [11:0] i_fb_n_0,
    input wire logic [3:0] i_fb_a_0,
    input wire logic [11:0] i_fb_n_1,
    input wire logic [11:0] i_fb_n_2,
    input wire logic [11:0] i_fb_n_3,
    input wire logic [5:0] i_prescale_select,
    input wire logic [41:0] i_qdiv,
    input wire logic [1:0] i_disabled_output_state,
    input wire logic [3:0] i_spread_step_period,
    output logic o_ref_clk,
    output logic o_on_secondary,
    output logic o_primary_lost,
    output logic o_undivided_output,
    output logic [5:0] o_bank_clk,
    output logic [5:0] o_bank_oe,
    output logic [5:0] o_bank_running,
    output logic [53:0] o_bank_ratio,
    output logic [12:0] o_load_cap_milli_pf,
    output logic o_ext_ref_settings_ok,
    output logic [13:0] o_fb_total_0,
    output logic [11:0] o_fb_total_1,
    output logic [11:0] o_fb_total_2,
    output logic [11:0] o_fb_total_3,
    output logic [6:0] o_ref_total_0,
    output logic [6:0] o_ref_total_1,
    output logic [6:0] o_ref_total_2,
    output logic [6:0] o_ref_total_3,
    output logic o_spread_active
);
    logic xtal_s1_r, xtal_s2_r, xtal_d_r;
    logic aux_s1_r, aux_s2_r, aux_d_r;
    logic sel_s1_r, sel_s2_r;
    logic prim_lvl, sec_lvl, prim_edge, sec_edge;
    logic auto_mode, lost;
    logic use_sec_r;
    refclk_pkg::src_state_t state_r, state_nxt;
    logic [13:0] m0;

    // Pins are foreign to this clock: two-stage synchronisers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_d_r <= 1'b0;
            aux_s1_r <= 1'b0;
            aux_s2_r <= 1'b0;
            aux_d_r <= 1'b0;
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
        end else if (i_ce) begin
            xtal_s1_r <= i_crystal_ref_input;
            xtal_s2_r <= xtal_s1_r;
            xtal_d_r <= xtal_s2_r;
            aux_s1_r <= i_auxiliary_clock_input;
            aux_s2_r <= aux_s1_r;
            aux_d_r <= aux_s2_r;
            sel_s1_r <= i_input_select_pin;
            sel_s2_r <= sel_s1_r;
        end
    end

    // Primary designation swaps the two inputs
    assign prim_lvl = i_primary_source_bit ? aux_s2_r : xtal_s2_r;
    assign sec_lvl = i_primary_source_bit ? xtal_s2_r : aux_s2_r;
    assign prim_edge = i_primary_source_bit ? (aux_s2_r ^ aux_d_r) : (xtal_s2_r ^ xtal_d_r);
    // Secondary cycles counted on rising edges only
    assign sec_edge = i_primary_source_bit ? (xtal_s2_r & ~xtal_d_r) : (aux_s2_r & ~aux_d_r);
    assign auto_mode = i_switchover_mode_field[1];

    loss_detect u_loss (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_prim_edge(prim_edge),
        .i_sec_edge(sec_edge),
        .o_lost(lost)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            refclk_pkg::SRC_PRIMARY: begin
                if (auto_mode && lost) state_nxt = refclk_pkg::SRC_SECONDARY;
            end
            refclk_pkg::SRC_SECONDARY: begin
                if (!auto_mode || prim_edge) state_nxt = refclk_pkg::SRC_REVERT;
            end
            refclk_pkg::SRC_REVERT: begin
                state_nxt = refclk_pkg::SRC_PRIMARY;
            end
            default: state_nxt = refclk_pkg::SRC_PRIMARY;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) state_r <= refclk_pkg::SRC_PRIMARY;
        else if (i_ce) state_r <= state_nxt;
    end

    // Switch only while both levels agree low, so no runt reaches the PLL
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            use_sec_r <= 1'b0;
        end else if (i_ce && !prim_lvl && !sec_lvl) begin
            if (auto_mode) use_sec_r <= (state_r == refclk_pkg::SRC_SECONDARY);
            else use_sec_r <= (sel_s2_r != i_primary_source_bit);
        end
    end

    // Sampled output: async to the references, edges may jitter by one tick
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_ref_clk <= 1'b0;
            o_undivided_output <= 1'b0;
        end else if (i_ce) begin
            o_ref_clk <= use_sec_r ? sec_lvl : prim_lvl;
            o_undivided_output <= use_sec_r ? sec_lvl : prim_lvl;
        end
    end

    assign o_on_secondary = use_sec_r;
    assign o_primary_lost = lost;

    genvar g;
    generate
        for (g = 0; g < refclk_pkg::NUM_BANKS; g++) begin : g_bank
            out_divider u_div (
                .i_clk_sys(i_clk_sys),
                .i_reset(i_reset),
                .i_ce(i_ce),
                .i_prescale_select(i_prescale_select[g]),
                .i_qdiv(i_qdiv[g*7 +: 7]),
                .i_disabled_output_state(i_disabled_output_state),
                .o_clk(o_bank_clk[g]),
                .o_oe(o_bank_oe[g]),
                .o_running(o_bank_running[g]),
                .o_ratio(o_bank_ratio[g*9 +: 9])
            );
        end
    endgenerate

    // Divider totals and static settings, registered
    assign m0 = (i_fb_a_0 != 4'h0) ? ({1'b0, i_fb_n_0, 1'b0} + {10'h000, i_fb_a_0} + 14'h0001)
                                   : {1'b0, i_fb_n_0, 1'b0};
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_fb_total_0 <= 14'h0000;
            o_fb_total_1 <= 12'h000;
            o_fb_total_2 <= 12'h000;
            o_fb_total_3 <= 12'h000;
            o_ref_total_0 <= 7'h00;
            o_ref_total_1 <= 7'h00;
            o_ref_total_2 <= 7'h00;
            o_ref_total_3 <= 7'h00;
            o_load_cap_milli_pf <= 13'(refclk_pkg::LOADCAP_BASE_MILLI_PF);
            o_ext_ref_settings_ok <= 1'b1;
            o_spread_active <= 1'b0;
        end else if (i_ce) begin
            o_fb_total_0 <= m0;
            o_fb_total_1 <= i_fb_n_1;
            o_fb_total_2 <= i_fb_n_2;
            o_fb_total_3 <= i_fb_n_3;
            o_ref_total_0 <= i_ref_div_0;
            o_ref_total_1 <= i_ref_div_1;
            o_ref_total_2 <= i_ref_div_2;
            o_ref_total_3 <= i_ref_div_3;
            o_load_cap_milli_pf <= 13'(refclk_pkg::LOADCAP_BASE_MILLI_PF)
                + 13'(i_load_cap_code) * 13'(refclk_pkg::LOADCAP_STEP_MILLI_PF);
            o_ext_ref_settings_ok <= (i_load_cap_code == refclk_pkg::LOADCAP_RESET)
                && (i_crystal_drive_strength == refclk_pkg::DRIVE_RESET);
            o_spread_active <= (i_spread_step_period != 4'h0);
        end
    end
endmodule

// ===== ref_clock_switchover_dividers_props.sv
// Checker for switchover, divider totals and output bank states
module ref_clock_switchover_dividers_props (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_input_select_pin,
    input wire logic i_primary_source_bit,
    input wire logic [1:0] i_switchover_mode_field,
    input wire logic [4:0] i_load_cap_code,
    input wire logic [11:0] i_fb_n_0,
    input wire logic [3:0] i_fb_a_0,
    input wire logic [1:0] i_disabled_output_state,
    input wire logic [3:0] i_spread_step_period,
    input wire logic o_on_secondary,
    input wire logic o_primary_lost,
    input wire logic [5:0] o_bank_clk,
    input wire logic [5:0] o_bank_oe,
    input wire logic [5:0] o_bank_running,
    input wire logic [12:0] o_load_cap_milli_pf,
    input wire logic [13:0] o_fb_total_0,
    input wire logic o_spread_active
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_LOADCAP: assert property (!$past(i_reset) && $past(i_ce) |->
        o_load_cap_milli_pf == 13'(3500 + 125 * $past(i_load_cap_code))) else $error("load cap");
    AST_SPREAD: assert property (!$past(i_reset) && $past(i_ce) |->
        o_spread_active == ($past(i_spread_step_period) != 4'h0)) else $error("spread enable");
    AST_FB0: assert property (!$past(i_reset) && $past(i_ce) |->
        o_fb_total_0 == 14'(2 * $past(i_fb_n_0) + ($past(i_fb_a_0) != 0 ? $past(i_fb_a_0) + 1 : 0)))
        else $error("first feedback total");
    AST_HIZ_OE: assert property (!o_bank_running[0] &&
        i_disabled_output_state == refclk_pkg::OEM_HIZ |-> !o_bank_oe[0]) else $error("hi-z oe");
    AST_DIS_STATIC: assert property ((!o_bank_running[0] && $stable(i_disabled_output_state)) [*3]
        |-> $stable(o_bank_clk[0])) else $error("disabled bank toggles");
    AST_AUTO_SW: assert property ($rose(o_primary_lost) && i_switchover_mode_field[1]
        |-> ##[1:12] (o_on_secondary || !o_primary_lost)) else $error("no switch on loss");
    AST_REVERT: assert property ($fell(o_primary_lost) && i_switchover_mode_field[1]
        |-> ##[1:20] !o_on_secondary) else $error("no revert");
    AST_MANUAL: assert property ((!i_switchover_mode_field[1] && $stable(i_input_select_pin)
        && $stable(i_primary_source_bit)) [*8]
        |-> ##[0:16] (o_on_secondary == (i_input_select_pin ^ i_primary_source_bit)))
        else $error("manual select");
    cover property ($rose(o_on_secondary));
    cover property ($fell(o_primary_lost));
    cover property (!o_bank_oe[0]);
endmodule
bind ref_clock_switchover_dividers ref_clock_switchover_dividers_props chk_i (.i_clk_sys, .i_reset,
    .i_ce, .i_input_select_pin, .i_primary_source_bit, .i_switchover_mode_field, .i_load_cap_code,
    .i_fb_n_0, .i_fb_a_0,
    .i_disabled_output_state, .i_spread_step_period, .o_on_secondary, .o_primary_lost, .o_bank_clk,
    .o_bank_oe, .o_bank_running, .o_load_cap_milli_pf, .o_fb_total_0, .o_spread_active);

// ===== ref_source_model.sv
// Behavioural model of the two external reference clock sources
module ref_source_model (
    input wire logic i_clk_sys,
    input wire logic i_run_pri,
    output logic o_crystal,
    output logic o_aux
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        o_crystal = 0;
        o_aux = 0;
    end
    // Aux is slower (6 ticks against 4), so with the crystal as primary the secondary never outruns it
    always @(negedge i_clk_sys) begin
        cnt <= cnt + 1;
        o_crystal <= i_run_pri ? (cnt % 4 < 2) : 1'b0;
        o_aux <= (cnt % 6 < 3);
    end
endmodule

// ===== ref_clock_switchover_dividers_test.sv
// Self-checking bench for reference switchover and divider block
module ref_clock_switchover_dividers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, xin, aux, sel = 0, psb = 0, run_p = 1, refclk, onsec, lost, extok, spr;
    logic undiv;
    logic [1:0] mode = 0, drv = 2'h3, oem = 0;
    logic [4:0] cap = 0;
    logic [3:0] fba = 0, tssc = 0;
    logic [27:0] rd = 0, rt;
    logic [47:0] fbn = 0;
    logic [35:0] ft;
    logic [5:0] pm = 0, bclk, boe, brun;
    logic [41:0] q = 0;
    logic [53:0] ratio;
    logic [12:0] capmpf;
    logic [13:0] fb0;
    logic [2:0] hp, hs;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    ref_source_model src (.i_clk_sys(clk), .i_run_pri(run_p), .o_crystal(xin), .o_aux(aux));
    ref_clock_switchover_dividers DUT (.i_clk_sys(clk), .i_reset(rst), .i_ce(1'b1),
        .i_crystal_ref_input(xin), .i_auxiliary_clock_input(aux), .i_input_select_pin(sel),
        .i_primary_source_bit(psb), .i_switchover_mode_field(mode), .i_load_cap_code(cap),
        .i_crystal_drive_strength(drv), .i_ref_div_0(rd[6:0]), .i_ref_div_1(rd[13:7]),
        .i_ref_div_2(rd[20:14]), .i_ref_div_3(rd[27:21]), .i_fb_n_0(fbn[11:0]), .i_fb_a_0(fba),
        .i_fb_n_1(fbn[23:12]), .i_fb_n_2(fbn[35:24]), .i_fb_n_3(fbn[47:36]),
        .i_prescale_select(pm), .i_qdiv(q), .i_disabled_output_state(oem),
        .i_spread_step_period(tssc), .o_ref_clk(refclk), .o_on_secondary(onsec),
        .o_primary_lost(lost), .o_undivided_output(undiv), .o_bank_clk(bclk), .o_bank_oe(boe),
        .o_bank_running(brun), .o_bank_ratio(ratio), .o_load_cap_milli_pf(capmpf),
        .o_ext_ref_settings_ok(extok), .o_fb_total_0(fb0), .o_fb_total_1(ft[11:0]),
        .o_fb_total_2(ft[23:12]), .o_fb_total_3(ft[35:24]), .o_ref_total_0(rt[6:0]),
        .o_ref_total_1(rt[13:7]), .o_ref_total_2(rt[20:14]), .o_ref_total_3(rt[27:21]),
        .o_spread_active(spr));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        hp <= {hp[1:0], xin};
        hs <= {hs[1:0], aux};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task t_cfg;
        for (int k = 0; k < 2; k++) begin
            cap = k ? 5'h1F : 5'h00;
            tssc = k ? 4'hE : 4'h0;
            fba = k ? 4'h3 : 4'h0;
            fbn = {12'hFFF, 12'h7D0, 12'h001, 12'h016};
            rd = {7'h7F, 7'h40, 7'h01, 7'h03};
            wt(2);
            chk(capmpf, 16'(3500 + 125 * cap));
            chk(extok, !k);
            chk(spr, k);
            chk(fb0, k ? 16'h0030 : 16'h002C);
            chk(ft[35:24], 16'h0FFF);
            chk(rt[27:21], 16'h007F);
            chk(rt[6:0], 16'h0003);
        end
        $display("test cfg done");
    endtask
    task t_div;
        logic [6:0] qt [6] = '{7'h7F, 7'h7F, 7'h05, 7'h05, 7'h00, 7'h7E};
        int ex [6] = '{0, 1, 2, 14, 2, 256};
        for (int i = 0; i < 6; i++) begin
            q = {qt[i], 28'h000_0000, qt[i]};
            pm = {i[0], 4'h0, i[0]};
            wt(3);
            chk(ratio[8:0], 16'(ex[i]));
            chk(ratio[53:45], 16'(ex[i]));
            chk(brun[0], ex[i] != 0);
        end
        // Bank 0 disabled so the idle pin level is what shows
        pm = 6'h00;
        q = {6{7'h7F}};
        for (int s = 0; s < 3; s++) begin
            oem = 2'(s);
            wt(3);
            chk(boe[0], oem != refclk_pkg::OEM_HIZ);
            if (s < 2) chk(bclk[0], oem == refclk_pkg::OEM_HIGH);
        end
        $display("test div done");
    endtask
    task t_manual;
        mode = 2'h0;
        for (int i = 0; i < 4; i++) begin
            {psb, sel} = 2'(i);
            wt(20);
            chk(onsec, sel ^ psb);
            for (int c = 0; c < 8; c++) begin
                chk(refclk, sel ? hs[2] : hp[2]);
                chk(undiv, refclk);
                wt(1);
            end
        end
        $display("test manual done");
    endtask
    task t_auto;
        logic [1:0] mt [3] = '{2'h2, 2'h3, 2'h1};
        {psb, sel} = 2'h0;
        for (int i = 0; i < 3; i++) begin
            mode = mt[i];
            wt(20);
            run_p = 0;
            wt(30);
            chk(onsec, mode[1]);
            if (mode[1]) chk(lost, 1);
            run_p = 1;
            wt(30);
            chk(onsec, 0);
            chk(lost, 0);
        end
        $display("test auto done");
    endtask
    task summarize;
        $display("counts fail=%0d compares=%0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        wt(8);
        rst = 0;
        t_cfg();
        t_div();
        t_manual();
        t_auto();
        summarize();
    end
endmodule
